/* verilog/fault_response_pkg.sv */
// Shared constants and carrier types for the fault response and alert block.
// Assumes a PMBus engine that hands over decoded commands on the same clock.
package fault_response_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int MS_IN_NS = 1000000;
  localparam int RETRY_MIN_MS = 120;
  localparam int RETRY_MAX_MS = 32700;
  localparam int MS_WIDTH = 15;

  localparam logic [7:0] CODE_OPERATION = 8'h01;
  localparam logic [7:0] CODE_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CODE_RESTORE = 8'h16;
  localparam logic [7:0] CODE_ALERT_MASK = 8'h1B;
  localparam logic [7:0] CODE_OT_RESP = 8'h50;
  localparam logic [7:0] CODE_UT_RESP = 8'h54;
  localparam logic [7:0] CODE_VIN_OV_RESP = 8'h56;
  localparam logic [7:0] CODE_TON_RESP = 8'h63;
  localparam logic [7:0] CODE_STATUS_BYTE = 8'h78;
  localparam logic [7:0] CODE_STATUS_WORD = 8'h79;
  localparam logic [7:0] CODE_STATUS_VOUT = 8'h7A;
  localparam logic [7:0] CODE_STATUS_IOUT = 8'h7B;
  localparam logic [7:0] CODE_STATUS_INPUT = 8'h7C;
  localparam logic [7:0] CODE_STATUS_TEMP = 8'h7D;
  localparam logic [7:0] CODE_STATUS_CML = 8'h7E;
  localparam logic [7:0] CODE_STATUS_MFR = 8'h80;
  localparam logic [7:0] CODE_CHAN_CONFIG = 8'hD0;
  localparam logic [7:0] CODE_PROPAGATE = 8'hD2;
  localparam logic [7:0] CODE_RESTART = 8'hDB;
  localparam logic [7:0] CODE_PAD_STATUS = 8'hE5;
  localparam logic [7:0] CODE_COMMON_STATUS = 8'hEF;
  localparam logic [7:0] CODE_SOFT_RESET = 8'hFD;

  localparam int SLOT_VOUT = 0;
  localparam int SLOT_IOUT = 1;
  localparam int SLOT_TEMP = 2;
  localparam int SLOT_CML = 3;
  localparam int SLOT_INPUT = 4;
  localparam int SLOT_MFR = 5;
  localparam int NUM_SLOTS = 6;

  localparam int RSP_VIN_OV = 0;
  localparam int RSP_OT = 1;
  localparam int RSP_UT = 2;
  localparam int RSP_TON = 3;
  localparam int NUM_RSP = 4;

  localparam int ACT_HI = 7;
  localparam int ACT_LO = 6;
  localparam int RETRY_HI = 5;
  localparam int RETRY_LO = 3;
  localparam int DELAY_HI = 2;
  localparam logic [1:0] ACT_IGNORE = 2'h0;
  localparam logic [1:0] ACT_SHUTDOWN = 2'h2;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;

  localparam int VOUT_OV_BIT = 7;
  localparam int VOUT_UV_BIT = 4;
  localparam int VOUT_TON_BIT = 2;
  localparam int IOUT_OC_BIT = 7;
  localparam int INPUT_OV_BIT = 7;
  localparam int TEMP_OT_BIT = 7;
  localparam int TEMP_UT_BIT = 4;
  localparam int CML_CMD_BIT = 7;
  localparam int CML_DATA_BIT = 6;
  localparam int MFR_INT_OT_BIT = 6;
  localparam int MFR_PLL_BIT = 4;
  localparam int MFR_PIN_BIT = 0;
  localparam int WORD_VOUT_BIT = 15;
  localparam int WORD_IOUT_BIT = 14;
  localparam int WORD_INPUT_BIT = 13;
  localparam int WORD_MFR_BIT = 12;
  localparam int BYTE_TEMP_BIT = 2;
  localparam int BYTE_CML_BIT = 1;

  localparam int PROP_DECAY = 15;
  localparam int PROP_SHORT = 14;
  localparam int PROP_TON = 13;
  localparam int PROP_INT_OT = 11;
  localparam int PROP_UT = 8;
  localparam int PROP_OT = 7;
  localparam int PROP_VIN_OV = 4;
  localparam int PROP_OC = 2;
  localparam int PROP_UV = 1;
  localparam int PROP_OV = 0;
  localparam logic [15:0] PROP_WRITABLE = 16'hE997;

  localparam int CHAN_DECAY_OFF_BIT = 0;
  localparam int OPER_ON_BIT = 7;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] MFR_MASK_RESET = 8'h11;
  localparam logic [7:0] RESP_RESET = 8'h80;
  localparam logic [15:0] RESTART_RESET = 16'h00FA;
  localparam logic [15:0] PROP_RESET = 16'h0000;
  localparam logic [7:0] CHAN_RESET = 8'h00;
  localparam logic [7:0] OPER_RESET = 8'h80;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] code;
    logic [15:0] data;
  } cmd_type;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } reply_type;

  typedef struct packed {
    logic vout_ov;
    logic vout_uv;
    logic iout_oc;
    logic vin_ov;
    logic ot;
    logic ut;
    logic int_ot;
    logic ton_max;
    logic short_cycle;
    logic pll_unlock;
  } detect_type;
endpackage

/* verilog/linear_ms_decoder.sv */
// Decodes a five-bit exponent, eleven-bit mantissa word into milliseconds.
// Assumes the word is stable for a cycle before the result is used.
module linear_ms_decoder
  import fault_response_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [15:0] i_word,
  output logic [MS_WIDTH-1:0] o_ms
);
  logic signed [4:0] expo;
  logic signed [10:0] mant;
  logic [31:0] mag;
  logic [31:0] next_ms;

  assign expo = i_word[15:11];
  assign mant = i_word[10:0];

  // Out-of-range words are clamped to the legal span, not rejected.
  always_comb begin
    mag = 32'h0;
    if (mant > 11'sh0) begin
      if (expo >= 5'sh0) begin
        mag = 32'(mant) << expo[3:0];
      end else begin
        mag = 32'(mant) >> 5'(-expo);
      end
    end
    if (mag < 32'(RETRY_MIN_MS)) begin
      next_ms = 32'(RETRY_MIN_MS);
    end else if (mag > 32'(RETRY_MAX_MS)) begin
      next_ms = 32'(RETRY_MAX_MS);
    end else begin
      next_ms = mag;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_ms <= MS_WIDTH'(RETRY_MIN_MS);
    end else begin
      o_ms <= next_ms[MS_WIDTH-1:0];
    end
  end
endmodule

/* verilog/restart_timer.sv */
// Millisecond down-counter for the restart interval.
// Assumes a one-cycle start pulse; start restarts a running count.
module restart_timer
  import fault_response_pkg::*;
#(
  parameter int CYCLES_PER_MS = MS_IN_NS / CLK_PERIOD_NS
)
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_start,
  input wire logic [MS_WIDTH-1:0] i_ms,
  output logic o_done
);
  // The tick counter is sixteen bits wide, so larger values cannot count.
  if (CYCLES_PER_MS < 1 || CYCLES_PER_MS > 65535) begin
    $error("restart_timer: CYCLES_PER_MS out of range");
  end

  logic [15:0] tick;
  logic [MS_WIDTH-1:0] left;

  always_ff @(posedge i_clk) begin
    if (i_reset || i_start || tick == 16'(CYCLES_PER_MS - 1)) begin
      tick <= 16'h0;
    end else begin
      tick <= tick + 16'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      left <= '0;
      o_done <= 1'b1;
    end else if (i_start) begin
      left <= i_ms;
      o_done <= 1'b0;
    end else if (!o_done && tick == 16'(CYCLES_PER_MS - 1)) begin
      left <= left - MS_WIDTH'(1);
      o_done <= (left == MS_WIDTH'(1));
    end
  end
endmodule

/* verilog/fault_response_alert_mask.sv */
// Fault response, restart timing, alert masking and FAULT pin propagation.
// Assumes a PMBus engine on i_clk delivering decoded commands and detectors
// and pins arriving asynchronously.
// Summary of operation
// - Startup timeout sets output-voltage summary and timeout status, alerts.
// - Every response code still sets status bits and alerts unless masked.
// - Action 00 keeps running; action 10 shuts down, then follows retry.
// - Action codes 01 or 11 are rejected and flag a comm fault.
// - Faults stay latched until cleared, written one, cycled or reset.
// - Retry 000 to 110 keeps output off until cleared or cycled.
// - Retry 111 restarts forever, spaced by the restart interval.
// - The low three delay bits of response bytes are ignored.
// - Restart interval in milliseconds, legal from 120 ms to 32.7 s.
// - Wait is longer of interval and output decay; decay check can be off.
// - Interval timing starts once fault gone and FAULT pin released.
// - Restart interval is decoded from exponent and mantissa linear word.
// - Mask write names status register and mask; masked bits skip alert.
// - Process call naming a status register returns its present mask.
// - Masking summary, common or pad status, or unknown codes, is refused.
// - Masks reset to zero, except vendor status which resets to 0x11.
// - Each propagation bit lets its condition pull FAULT low.
// - A condition whose response is ignore never pulls FAULT low.
// - Alert masks have no effect on FAULT propagation.
// - Propagation bit map fixed; reserved bits are held at zero.
module fault_response_alert_mask
  import fault_response_pkg::*;
#(
  parameter int CYCLES_PER_MS = MS_IN_NS / CLK_PERIOD_NS
)
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire cmd_type i_cmd,
  output reply_type o_reply,
  input wire detect_type i_detect,
  input wire logic i_run,
  input wire logic i_vout_low,
  input wire logic i_fault_pin,
  output logic o_fault_out,
  output logic o_fault_oe,
  output logic o_alert_out,
  output logic o_alert_oe,
  output logic o_output_enable
);
  typedef enum logic [4:0] {
    ST_OFF = 5'h01,
    ST_RUN = 5'h02,
    ST_LATCHED = 5'h04,
    ST_WAIT_CLEAR = 5'h08,
    ST_DELAY = 5'h10
  } state_type;

  state_type state, next_state;
  detect_type det_meta, det;
  logic [2:0] pin_meta, pin_sync;
  logic run_s, vout_low, pin_high, commanded, commanded_q;
  logic wr, rd, clear_all, resp_hit, slot_hit, mask_slot_hit;
  logic [1:0] resp_idx;
  logic [2:0] slot_idx, mask_slot;
  logic [7:0] resp [NUM_RSP];
  logic [7:0] mask [NUM_SLOTS];
  logic [7:0] status [NUM_SLOTS];
  logic [7:0] set_bits [NUM_SLOTS];
  logic [7:0] clr_bits [NUM_SLOTS];
  logic [15:0] restart_word, propagate;
  logic [7:0] chan_config, operation;
  logic [NUM_RSP-1:0] live, ignored, sd_live, retry_inf;
  logic any_sd, noretry, decay_off, timer_done, waiting_decay;
  logic err_cmd, err_data, alert_pending, fault_drive;
  logic [1:0] oe_hist;
  logic [15:0] prop_cond, status_word;
  logic [MS_WIDTH-1:0] restart_ms;

  // Pins and analog detectors are asynchronous to i_clk.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      det_meta <= '0;
      det <= '0;
      pin_meta <= 3'h1;
      pin_sync <= 3'h1;
    end else begin
      det_meta <= i_detect;
      det <= det_meta;
      pin_meta <= {i_run, i_vout_low, i_fault_pin};
      pin_sync <= pin_meta;
    end
  end

  assign run_s = pin_sync[2];
  assign vout_low = pin_sync[1];
  assign pin_high = pin_sync[0];
  assign commanded = run_s & operation[OPER_ON_BIT];
  assign wr = i_cmd.valid & i_cmd.write;
  assign rd = i_cmd.valid & ~i_cmd.write;

  always_comb begin
    resp_hit = 1'b1;
    resp_idx = 2'(RSP_TON);
    unique case (i_cmd.code)
      CODE_VIN_OV_RESP: resp_idx = 2'(RSP_VIN_OV);
      CODE_OT_RESP: resp_idx = 2'(RSP_OT);
      CODE_UT_RESP: resp_idx = 2'(RSP_UT);
      CODE_TON_RESP: resp_idx = 2'(RSP_TON);
      default: resp_hit = 1'b0;
    endcase
  end

  function automatic logic [3:0] slot_of(input logic [7:0] code);
    logic [3:0] r;
    r = 4'h0;
    unique case (code)
      CODE_STATUS_VOUT: r = {1'b1, 3'(SLOT_VOUT)};
      CODE_STATUS_IOUT: r = {1'b1, 3'(SLOT_IOUT)};
      CODE_STATUS_TEMP: r = {1'b1, 3'(SLOT_TEMP)};
      CODE_STATUS_CML: r = {1'b1, 3'(SLOT_CML)};
      CODE_STATUS_INPUT: r = {1'b1, 3'(SLOT_INPUT)};
      CODE_STATUS_MFR: r = {1'b1, 3'(SLOT_MFR)};
      default: r = 4'h0;
    endcase
    return r;
  endfunction

  assign {slot_hit, slot_idx} = slot_of(i_cmd.code);
  assign {mask_slot_hit, mask_slot} = slot_of(i_cmd.data[7:0]);

  assign clear_all = (wr && (i_cmd.code == CODE_CLEAR_FAULTS
                    || i_cmd.code == CODE_RESTORE
                    || i_cmd.code == CODE_SOFT_RESET))
                    || (commanded && !commanded_q);

  always_comb begin
    err_cmd = 1'b0;
    err_data = 1'b0;
    if (i_cmd.valid) begin
      if (i_cmd.code == CODE_ALERT_MASK) begin
        err_data = !mask_slot_hit;
      end else if (resp_hit) begin
        err_data = wr && i_cmd.data[ACT_LO];
      end else if (!(slot_hit || i_cmd.code == CODE_STATUS_WORD
                  || i_cmd.code == CODE_STATUS_BYTE
                  || i_cmd.code == CODE_OPERATION
                  || i_cmd.code == CODE_CHAN_CONFIG
                  || i_cmd.code == CODE_PROPAGATE
                  || i_cmd.code == CODE_RESTART)) begin
        err_cmd = !(wr && (i_cmd.code == CODE_CLEAR_FAULTS
                   || i_cmd.code == CODE_RESTORE
                   || i_cmd.code == CODE_SOFT_RESET));
      end
    end
  end

  // Delay bits are dropped on write.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      for (int i = 0; i < NUM_RSP; i++) begin
        resp[i] <= RESP_RESET;
      end
    end else if (wr && resp_hit && !i_cmd.data[ACT_LO]) begin
      resp[resp_idx] <= {i_cmd.data[ACT_HI:RETRY_LO], 3'h0};
    end
  end

  // Mask write selects register by first data byte.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        mask[i] <= (i == SLOT_MFR) ? MFR_MASK_RESET : MASK_RESET;
      end
    end else if (wr && i_cmd.code == CODE_ALERT_MASK && mask_slot_hit) begin
      mask[mask_slot] <= i_cmd.data[15:8];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      restart_word <= RESTART_RESET;
      propagate <= PROP_RESET;
      chan_config <= CHAN_RESET;
      operation <= OPER_RESET;
    end else if (wr) begin
      if (i_cmd.code == CODE_RESTART) begin
        restart_word <= i_cmd.data;
      end
      // Reserved propagation bits held at zero.
      if (i_cmd.code == CODE_PROPAGATE) begin
        propagate <= i_cmd.data & PROP_WRITABLE;
      end
      if (i_cmd.code == CODE_CHAN_CONFIG) begin
        chan_config <= i_cmd.data[7:0];
      end
      if (i_cmd.code == CODE_OPERATION) begin
        operation <= i_cmd.data[7:0];
      end
    end
  end

  assign live = {det.ton_max, det.ut, det.ot, det.vin_ov};
  always_comb begin
    for (int i = 0; i < NUM_RSP; i++) begin
      ignored[i] = resp[i][ACT_HI:ACT_LO] == ACT_IGNORE;
      sd_live[i] = live[i] && resp[i][ACT_HI:ACT_LO] == ACT_SHUTDOWN;
      retry_inf[i] = resp[i][RETRY_HI:RETRY_LO] == RETRY_FOREVER;
    end
  end
  assign any_sd = |sd_live;
  assign noretry = |(sd_live & ~retry_inf);

  // Status bits set regardless of action code.
  always_comb begin
    for (int i = 0; i < NUM_SLOTS; i++) begin
      set_bits[i] = 8'h0;
      clr_bits[i] = clear_all ? 8'hFF : 8'h0;
    end
    set_bits[SLOT_VOUT][VOUT_TON_BIT] = det.ton_max;
    set_bits[SLOT_VOUT][VOUT_OV_BIT] = det.vout_ov;
    set_bits[SLOT_VOUT][VOUT_UV_BIT] = det.vout_uv;
    set_bits[SLOT_IOUT][IOUT_OC_BIT] = det.iout_oc;
    set_bits[SLOT_TEMP][TEMP_OT_BIT] = det.ot;
    set_bits[SLOT_TEMP][TEMP_UT_BIT] = det.ut;
    set_bits[SLOT_INPUT][INPUT_OV_BIT] = det.vin_ov;
    set_bits[SLOT_CML][CML_CMD_BIT] = err_cmd;
    set_bits[SLOT_CML][CML_DATA_BIT] = err_data;
    set_bits[SLOT_MFR][MFR_INT_OT_BIT] = det.int_ot;
    set_bits[SLOT_MFR][MFR_PLL_BIT] = det.pll_unlock;
    // Our own pull reaches pin_high two edges late, so it is excluded too.
    set_bits[SLOT_MFR][MFR_PIN_BIT] = !pin_high && !o_fault_oe
                                      && !(|oe_hist);
    if (wr && slot_hit) begin
      clr_bits[slot_idx] = clr_bits[slot_idx] | i_cmd.data[7:0];
    end
  end

  // Set wins over any clear in the same cycle.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        status[i] <= 8'h0;
      end
    end else begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        status[i] <= (status[i] & ~clr_bits[i]) | set_bits[i];
      end
    end
  end

  always_comb begin
    alert_pending = 1'b0;
    for (int i = 0; i < NUM_SLOTS; i++) begin
      alert_pending = alert_pending | (|(status[i] & ~mask[i]));
    end
  end

  assign status_word = {|status[SLOT_VOUT], |status[SLOT_IOUT],
                        |status[SLOT_INPUT], |status[SLOT_MFR], 4'h0,
                        5'h0, |status[SLOT_TEMP], |status[SLOT_CML], 1'b0};

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_reply <= '0;
    end else begin
      o_reply.valid <= rd && !err_cmd && !err_data;
      o_reply.data <= 16'h0;
      if (rd && slot_hit) begin
        o_reply.data <= {8'h0, status[slot_idx]};
      end else if (rd && resp_hit) begin
        o_reply.data <= {8'h0, resp[resp_idx]};
      end else if (rd && i_cmd.code == CODE_ALERT_MASK && mask_slot_hit) begin
        o_reply.data <= {8'h0, mask[mask_slot]};
      end else if (rd) begin
        unique case (i_cmd.code)
          CODE_STATUS_WORD: o_reply.data <= status_word;
          CODE_STATUS_BYTE: o_reply.data <= {8'h0, status_word[7:0]};
          CODE_RESTART: o_reply.data <= restart_word;
          CODE_PROPAGATE: o_reply.data <= propagate;
          CODE_CHAN_CONFIG: o_reply.data <= {8'h0, chan_config};
          CODE_OPERATION: o_reply.data <= {8'h0, operation};
          default: o_reply.data <= 16'h0;
        endcase
      end
    end
  end

  linear_ms_decoder u_decode (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_word(restart_word),
    .o_ms(restart_ms)
  );

  restart_timer #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_timer (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_start(state == ST_WAIT_CLEAR && next_state == ST_DELAY),
    .i_ms(restart_ms),
    .o_done(timer_done)
  );

  assign decay_off = chan_config[CHAN_DECAY_OFF_BIT];
  assign waiting_decay = state == ST_DELAY && !vout_low && !decay_off;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_OFF: if (commanded) begin
        next_state = ST_RUN;
      end
      ST_RUN: if (any_sd) begin
        // A no-retry response wins over retry.
        next_state = noretry ? ST_LATCHED : ST_WAIT_CLEAR;
      end
      ST_LATCHED: if (clear_all) begin
        next_state = ST_RUN;
      end
      ST_WAIT_CLEAR: if (noretry) begin
        next_state = ST_LATCHED;
      end else if (!any_sd && pin_high) begin
        // Timing starts after fault and pin release.
        next_state = ST_DELAY;
      end
      ST_DELAY: if (any_sd) begin
        next_state = noretry ? ST_LATCHED : ST_WAIT_CLEAR;
      end else if (timer_done && !waiting_decay) begin
        next_state = ST_RUN;
      end
      default: next_state = ST_OFF;
    endcase
    if (!commanded) begin
      next_state = ST_OFF;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state <= ST_OFF;
      commanded_q <= 1'b0;
      o_output_enable <= 1'b0;
    end else begin
      state <= next_state;
      commanded_q <= commanded;
      o_output_enable <= next_state == ST_RUN;
    end
  end

  always_comb begin
    prop_cond = 16'h0;
    prop_cond[PROP_DECAY] = waiting_decay;
    prop_cond[PROP_SHORT] = det.short_cycle;
    prop_cond[PROP_TON] = det.ton_max && !ignored[RSP_TON];
    prop_cond[PROP_INT_OT] = det.int_ot;
    prop_cond[PROP_UT] = det.ut && !ignored[RSP_UT];
    prop_cond[PROP_OT] = det.ot && !ignored[RSP_OT];
    prop_cond[PROP_VIN_OV] = det.vin_ov && !ignored[RSP_VIN_OV];
    prop_cond[PROP_OC] = det.iout_oc;
    prop_cond[PROP_UV] = det.vout_uv;
    prop_cond[PROP_OV] = det.vout_ov;
  end
  // Masks play no part in the pin drive.
  assign fault_drive = |(propagate & prop_cond);

  // Open-drain pins: the output level is always low, only enables move.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_fault_oe <= 1'b0;
      oe_hist <= 2'h0;
      o_alert_oe <= 1'b0;
      o_fault_out <= 1'b0;
      o_alert_out <= 1'b0;
    end else begin
      o_fault_oe <= fault_drive;
      oe_hist <= {oe_hist[0], o_fault_oe};
      o_alert_oe <= alert_pending;
      o_fault_out <= 1'b0;
      o_alert_out <= 1'b0;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  chk_ton_status: assert property (det.ton_max |=>
    status[SLOT_VOUT][VOUT_TON_BIT] ##1 o_alert_oe
    || mask[SLOT_VOUT][VOUT_TON_BIT])
    else $error("startup timeout status not set");
  chk_alert_follow: assert property (alert_pending |=> o_alert_oe)
    else $error("alert not asserted for unmasked status");
  chk_ignore_runs: assert property (
    state == ST_RUN && commanded && !any_sd |=> o_output_enable)
    else $error("output dropped without shutdown fault");
  chk_shutdown_now: assert property (
    state == ST_RUN && any_sd |=> !o_output_enable)
    else $error("output not disabled at once");
  chk_bad_action: assert property (
    wr && resp_hit && i_cmd.data[ACT_LO]
    |=> status[SLOT_CML][CML_DATA_BIT] && $stable(resp[0])
    && $stable(resp[1]) && $stable(resp[2]) && $stable(resp[3]))
    else $error("unsupported action code accepted");
  chk_latched_hold: assert property (
    state == ST_LATCHED && commanded && !clear_all |=> state == ST_LATCHED)
    else $error("latched shutdown left without clear");
  chk_retry_path: assert property (
    state == ST_RUN && commanded && any_sd && !noretry
    |=> state == ST_WAIT_CLEAR ##[1:3] !o_output_enable)
    else $error("retry response did not wait");
  chk_delay_zero: assert property (
    (resp[0][DELAY_HI:0] | resp[1][DELAY_HI:0] | resp[2][DELAY_HI:0]
    | resp[3][DELAY_HI:0]) == 3'h0)
    else $error("delay bits stored");
  chk_decay_gate: assert property (
    $past(state) == ST_DELAY && state == ST_RUN
    |-> $past(timer_done) && ($past(vout_low) || $past(decay_off)))
    else $error("restart before interval and decay");
  chk_wait_release: assert property (
    state == ST_WAIT_CLEAR && (any_sd || !pin_high) |=> state != ST_DELAY)
    else $error("interval started while fault held");
  chk_mask_refused: assert property (
    wr && i_cmd.code == CODE_ALERT_MASK && !mask_slot_hit
    |=> status[SLOT_CML][CML_DATA_BIT])
    else $error("refused mask target not flagged");

  cov_retry_restart: cover property (state == ST_DELAY ##1 state == ST_RUN);
  cov_latched: cover property (state == ST_LATCHED);
  cov_alert: cover property (o_alert_oe && o_fault_oe);
endmodule

/* verification/fault_wire_peer.sv */
// Pull-up wires for FAULT and ALERT, with a peer that may pull FAULT low.
// Assumes open-drain enables from the device, high while it pulls low.
module fault_wire_peer (
  input wire logic i_fault_oe,
  input wire logic i_alert_oe,
  input wire logic i_peer_pull,
  output logic o_fault_pin,
  output logic o_alert_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pull-ups win when nobody drives, so the idle level is high.
  assign o_fault_pin = !(i_fault_oe || i_peer_pull);
  assign o_alert_pin = !i_alert_oe;
endmodule

/* verification/tb.sv */
// Self-checking bench for the fault response and alert block.
// Assumes one-cycle decoded commands and CYCLES_PER_MS set to 10.
module tb import fault_response_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, run, vlow, pull, fault_pin, fault_oe, alert_oe, out_en;
  cmd_type cmd;
  reply_type reply;
  detect_type det;
  logic [15:0] got;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  fault_response_alert_mask #(.CYCLES_PER_MS(10)) dut (.i_clk(clk),
    .i_reset(rst), .i_cmd(cmd), .o_reply(reply), .i_detect(det),
    .i_run(run), .i_vout_low(vlow), .i_fault_pin(fault_pin),
    .o_fault_out(), .o_fault_oe(fault_oe), .o_alert_out(),
    .o_alert_oe(alert_oe), .o_output_enable(out_en));
  fault_wire_peer peer (.i_fault_oe(fault_oe), .i_alert_oe(alert_oe),
    .i_peer_pull(pull), .o_fault_pin(fault_pin), .o_alert_pin());
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic final_report();
    if (num_errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // The ceiling is well above the longest restart wait of the run.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      final_report();
    end
  end
  task automatic chk(string name, logic [15:0] exp, logic [15:0] seen);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // A read with no reply pulse yields unknown data, so its check fails.
  task automatic send(logic wr, logic [7:0] code, logic [15:0] data);
    @(negedge clk);
    cmd = {1'b1, wr, code, data};
    @(negedge clk);
    cmd = '0;
    got = reply.data;
    if (!wr && reply.valid !== 1'b1) got = 16'hXXXX;
  endtask
  task automatic idle(int n);
    repeat (n) @(negedge clk);
  endtask
  initial begin
    rst = 1'b1;
    run = 1'b0;
    vlow = 1'b1;
    pull = 1'b0;
    cmd = '0;
    det = '0;
    idle(12);
    rst = 1'b0;
    run = 1'b1;
    idle(5);
    chk("out_en", 16'h0001, 16'(out_en));
    send(1'b0, 8'h1B, 16'h007A);
    chk("vout_mask", 16'h0000, got);
    send(1'b0, 8'h1B, 16'h0080);
    chk("mfr_mask", 16'h0011, got);
    send(1'b1, 8'h1B, 16'h407D);
    send(1'b0, 8'h1B, 16'h007D);
    chk("temp_mask", 16'h0040, got);
    send(1'b1, 8'h1B, 16'h4079);
    send(1'b0, 8'h7E, 16'h0000);
    chk("cml_mask_refuse", 16'h0040, got);
    idle(3);
    chk("alert_set", 16'h0001, 16'(alert_oe));
    send(1'b1, 8'h03, 16'h0000);
    send(1'b1, 8'h63, 16'h0040);
    send(1'b0, 8'h7E, 16'h0000);
    chk("cml_bad_action", 16'h0040, got);
    send(1'b0, 8'h63, 16'h0000);
    chk("ton_kept", 16'h0080, got);
    send(1'b1, 8'h03, 16'h0000);
    idle(3);
    chk("alert_clear", 16'h0000, 16'(alert_oe));
    send(1'b1, 8'hD2, 16'h2000);
    send(1'b1, 8'h63, 16'h0000);
    det.ton_max = 1'b1;
    idle(6);
    chk("ignore_fault", 16'h0000, 16'(fault_oe));
    chk("ignore_run", 16'h0001, 16'(out_en));
    send(1'b0, 8'h7A, 16'h0000);
    chk("ignore_status", 16'h0004, got);
    det.ton_max = 1'b0;
    send(1'b1, 8'h63, 16'h0080);
    send(1'b1, 8'h03, 16'h0000);
    det.ton_max = 1'b1;
    idle(6);
    chk("prop_fault", 16'h0001, 16'(fault_oe));
    chk("shut_off", 16'h0000, 16'(out_en));
    send(1'b0, 8'h79, 16'h0000);
    chk("word_vout", 16'h0001, 16'(got[15]));
    det.ton_max = 1'b0;
    idle(3000);
    chk("no_retry", 16'h0000, 16'(out_en));
    send(1'b1, 8'h03, 16'h0000);
    idle(10);
    chk("cleared_on", 16'h0001, 16'(out_en));
    send(1'b1, 8'h63, 16'h00BF);
    send(1'b0, 8'h63, 16'h0000);
    chk("delay_ignored", 16'h00B8, got);
    // 150 ms as mantissa 300 with exponent minus one.
    send(1'b1, 8'hDB, 16'hF92C);
    send(1'b0, 8'hDB, 16'h0000);
    chk("restart_word", 16'hF92C, got);
    det.ton_max = 1'b1;
    idle(6);
    det.ton_max = 1'b0;
    pull = 1'b1;
    idle(2000);
    chk("pin_hold", 16'h0000, 16'(out_en));
    send(1'b0, 8'h80, 16'h0000);
    chk("pin_low_status", 16'h0001, got);
    pull = 1'b0;
    idle(1300);
    chk("retry_wait", 16'h0000, 16'(out_en));
    for (int i = 0; i < 700 && out_en !== 1'b1; i++) idle(1);
    chk("retry_on", 16'h0001, 16'(out_en));
    send(1'b1, 8'hD2, 16'hA000);
    det.ton_max = 1'b1;
    vlow = 1'b0;
    idle(6);
    det.ton_max = 1'b0;
    idle(2000);
    chk("decay_wait", 16'h0000, 16'(out_en));
    chk("decay_fault", 16'h0001, 16'(fault_oe));
    vlow = 1'b1;
    idle(10);
    chk("decay_done", 16'h0001, 16'(out_en));
    send(1'b1, 8'hD0, 16'h0001);
    det.ton_max = 1'b1;
    vlow = 1'b0;
    idle(6);
    det.ton_max = 1'b0;
    idle(1600);
    chk("decay_off", 16'h0001, 16'(out_en));
    final_report();
  end
endmodule
